// *** bench/av_panel_properties.sv ***
// Checker for the front-panel control; it sees only the top-level ports.
`timescale 1ns/1ps
module av_panel_properties #(
  parameter int unsigned FLASH_CYC = av_panel_pkg::FLASH_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  same_code,
  input  wire logic [7:0]            warm_secs,
  input  wire logic [7:0]            cool_secs,
  input  av_panel_pkg::nv_settings_t settings,
  input  wire logic                  nv_write,
  input  av_panel_pkg::led_t         leds,
  input  av_panel_pkg::serial_req_t  serial_req,
  input  wire logic [3:0]            eq_hf_level
);
  import av_panel_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  int unsigned cyc;
  logic [2:0]  last_proj;
  logic        run;
  // Counts edges since reset release and keeps the last projector string sent.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cyc       <= 0;
      last_proj <= STR_PROJ_OFF;
    end
    else
    begin
      cyc <= (cyc < 100000) ? cyc + 1 : cyc;
      if (serial_req.valid && serial_req.id[2])
        last_proj <= serial_req.id;
    end
  end
  // Normal operation starts once the self-test flashes have passed.
  assign run = cyc > 2 * FLASH_CYC + 3;
  sequence s_on_req;
    serial_req.valid && serial_req.id == STR_PROJ_ON && warm_secs == 8'h00 && !same_code;
  endsequence
  sequence s_off_req;
    serial_req.valid && serial_req.id == STR_PROJ_OFF && cool_secs == 8'h00 && !same_code;
  endsequence
  chk_test_on: assert property (cyc >= 2 && cyc < FLASH_CYC |-> leds == LED_ALL_ON)
    else $error("self-test leds not all on");
  chk_test_off: assert property (cyc > FLASH_CYC + 1 && cyc < 2 * FLASH_CYC |-> leds == LED_ALL_OFF)
    else $error("self-test leds not all off");
  chk_no_early: assert property (!run |-> !serial_req.valid)
    else $error("string sent during self-test");
  chk_write_pulse: assert property (nv_write |=> !nv_write)
    else $error("store pulse too long");
  chk_write_change: assert property (nv_write |-> settings != $past(settings))
    else $error("store pulse without change");
  chk_proj_order: assert property (serial_req.valid && serial_req.id[2] |-> serial_req.id != last_proj)
    else $error("projector strings do not alternate");
  chk_proj_on: assert property (s_on_req |-> ##[1:2] leds.proj_green)
    else $error("projector led not lit after on");
  chk_proj_off: assert property (s_off_req |-> ##[1:2] !leds.proj_green)
    else $error("projector led lit after off");
  chk_blank_led: assert property (run |-> leds.blank == $past(settings.blank))
    else $error("blank led mismatch");
  chk_mute_led: assert property (run |-> leds.mute == $past(settings.mute))
    else $error("mute led mismatch");
  chk_sel_led: assert property (run |-> leds.in_sel == (4'h1 << $past(settings.sel)))
    else $error("input led mismatch");
  chk_vol_step: assert property (run && $changed(settings.volume)
    |-> 7'(settings.volume - $past(settings.volume)) inside {7'h01, 7'h7F})
    else $error("volume step not one");
  chk_eq_step: assert property ($changed(eq_hf_level)
    |-> 4'(eq_hf_level - $past(eq_hf_level)) inside {4'h1, 4'hF})
    else $error("equalization step not one");
  chk_power_leds: assert property (run |-> leds.tx_power && leds.rx_power && leds.eq_hf != leds.eq_lf)
    else $error("power or band leds wrong");
endmodule : av_panel_properties

// *** bench/panel_partner.sv ***
// Operator and receiver stand-in: pushes buttons and logs strings forwarded to the display.
`timescale 1ns/1ps
module panel_partner (
  input  wire logic                         sys_clk,
  input  av_panel_pkg::serial_req_t         serial_req,
  output logic [av_panel_pkg::NUM_BTN-1:0]  buttons_n = '1
);
  import av_panel_pkg::*;
  logic [2:0] last_id = 3'h7;
  int         n_req   = 0;
  // The receiver passes each string on unchanged; the log stands for its serial port.
  always @(posedge sys_clk)
  begin
    if (serial_req.valid === 1'h1)
    begin
      last_id <= serial_req.id;
      n_req   <= n_req + 1;
    end
  end
  // Sets one button pin level at a clock edge; released pins rest high.
  task automatic set_btn(input int idx, input logic lvl);
    @(posedge sys_clk);
    buttons_n[idx] <= lvl;
  endtask : set_btn
  // Holds one button for n + 1 cycles, then leaves it released long enough to settle.
  task automatic push(input int idx, input int n);
    set_btn(idx, 1'h0);
    repeat (n) @(posedge sys_clk);
    set_btn(idx, 1'h1);
    repeat (20) @(posedge sys_clk);
  endtask : push
endmodule : panel_partner

// *** bench/tb_top.sv ***
// Self-checking bench of the front-panel control with its operator and receiver model.
`timescale 1ns/1ps
module tb_top;
  import av_panel_pkg::*;
  typedef struct {int btn; logic [1:0] sel; logic blank; logic mute; logic [6:0] vol; int ser;
                  logic [3:0] hf; logic [3:0] lf;} row_t;
  logic               sys_clk      = 1'h0;
  logic               reset_n      = 1'h0;
  logic [NUM_BTN-1:0] buttons_n;
  logic [NUM_IN-1:0]  str_present  = 4'h4;
  logic               same_code    = 1'h0;
  logic [7:0]         warm_secs    = 8'h00;
  logic [7:0]         cool_secs    = 8'h00;
  logic               autooff_en   = 1'h0;
  logic [15:0]        autooff_secs = 16'h0002;
  nv_settings_t       nv_data      = {2'h3, {4{5'h10}}, 7'h30, 1'h0, 1'h1};
  logic               nv_valid     = 1'h1;
  nv_settings_t       settings;
  logic               nv_write;
  led_t               leds;
  serial_req_t        serial_req;
  logic [3:0]         eq_hf_level;
  logic [3:0]         eq_lf_level;
  int                 n_mismatch   = 0;
  int                 n_compared   = 0;
  int                 c;
  int                 ones;
  logic [6:0]         v;
  row_t rows[12] = '{
    '{2, 2'h2, 1'h0, 1'h1, 7'h30, 2, 4'h8, 4'h8}, '{1, 2'h1, 1'h0, 1'h1, 7'h30, -1, 4'h8, 4'h8},
    '{BTN_BLANK, 2'h1, 1'h1, 1'h1, 7'h30, -1, 4'h8, 4'h8}, '{BTN_BLANK, 2'h1, 1'h0, 1'h1, 7'h30, -1, 4'h8, 4'h8},
    '{BTN_MUTE, 2'h1, 1'h0, 1'h0, 7'h30, -1, 4'h8, 4'h8}, '{BTN_VUP, 2'h1, 1'h0, 1'h0, 7'h31, -1, 4'h8, 4'h8},
    '{BTN_VDN, 2'h1, 1'h0, 1'h0, 7'h30, -1, 4'h8, 4'h8}, '{BTN_PROJ, 2'h1, 1'h0, 1'h0, 7'h30, 4, 4'h8, 4'h8},
    '{BTN_PROJ, 2'h1, 1'h0, 1'h0, 7'h30, 5, 4'h8, 4'h8}, '{BTN_EQP, 2'h1, 1'h0, 1'h0, 7'h30, -1, 4'h9, 4'h8},
    '{BTN_EQSEL, 2'h1, 1'h0, 1'h0, 7'h30, -1, 4'h9, 4'h8}, '{BTN_EQM, 2'h1, 1'h0, 1'h0, 7'h30, -1, 4'h9, 4'h7}};
  // Free-running 50 MHz system clock.
  always #10 sys_clk = ~sys_clk;
  av_panel_control #(.DEBOUNCE_CYC(4), .HOLD_CYC(40), .REPEAT_CYC(10), .BLINK_CYC(8), .BURST_CYC(64),
    .FLASH_CYC(20), .SEC_CYC(50)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .buttons_n(buttons_n),
    .str_present(str_present), .same_code(same_code), .warm_secs(warm_secs), .cool_secs(cool_secs),
    .autooff_en(autooff_en), .autooff_secs(autooff_secs), .nv_data(nv_data), .nv_valid(nv_valid),
    .settings(settings), .nv_write(nv_write), .leds(leds), .serial_req(serial_req),
    .eq_hf_level(eq_hf_level), .eq_lf_level(eq_lf_level));
  panel_partner u_far (.sys_clk(sys_clk), .serial_req(serial_req), .buttons_n(buttons_n));
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Counts lit cycles of the projector led over one blink period.
  task automatic count_blink();
    ones = 0;
    repeat (16)
    begin
      @(negedge sys_clk);
      ones += int'(leds.proj_green);
    end
  endtask : count_blink
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
  // Main sequence: restore, table of presses, then the awkward cases.
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'h1;
    repeat (45) @(posedge sys_clk);
    check(settings, nv_data);
    check({leds.in_sel, leds.mute, leds.tx_power, leds.rx_power, leds.eq_hf}, 8'h8F);
    foreach (rows[i])
    begin
      c = u_far.n_req;
      u_far.push(rows[i].btn, 12);
      check(settings.sel, rows[i].sel);
      check({settings.blank, leds.blank}, {2{rows[i].blank}});
      check({settings.mute, leds.mute}, {2{rows[i].mute}});
      check(settings.volume, rows[i].vol);
      check({eq_hf_level, eq_lf_level}, {rows[i].hf, rows[i].lf});
      check(u_far.n_req - c, (rows[i].ser < 0) ? 0 : 1);
      if (rows[i].ser >= 0)
        check(u_far.last_id, rows[i].ser);
    end
    check(leds.eq_lf, 1'h1);
    str_present <= ~str_present;
    c = u_far.n_req;
    u_far.push(3, 12);
    check({u_far.n_req - c, u_far.last_id}, {32'h1, 3'h3});
    u_far.push(BTN_MUTE, 2);
    check(settings.mute, 1'h0);
    u_far.push(BTN_VUP, 80);
    check(settings.volume > 7'h33 && settings.volume < 7'h37, 1'h1);
    u_far.set_btn(0, 1'h0);
    repeat (20) @(posedge sys_clk);
    v = settings.volume;
    u_far.push(BTN_VUP, 12);
    check({settings.level[0], settings.volume}, {5'h11, v});
    u_far.set_btn(0, 1'h1);
    repeat (20) @(posedge sys_clk);
    warm_secs <= 8'h01;
    u_far.push(BTN_PROJ, 12);
    count_blink();
    check(ones > 0 && ones < 16, 1'h1);
    u_far.push(BTN_BLANK, 12);
    check(settings.blank, 1'h0);
    repeat (10) @(posedge sys_clk);
    check(leds.proj_green, 1'h1);
    cool_secs <= warm_secs;
    warm_secs <= 8'h00;
    u_far.push(BTN_PROJ, 12);
    count_blink();
    check(ones > 0 && ones < 16, 1'h1);
    repeat (30) @(posedge sys_clk);
    cool_secs <= 8'h00;
    check(leds.proj_green, 1'h0);
    autooff_en <= 1'h1;
    u_far.push(BTN_PROJ, 12);
    check(u_far.last_id, STR_PROJ_ON);
    c = u_far.n_req;
    repeat (100) @(posedge sys_clk);
    check({u_far.n_req - c, u_far.last_id, leds.proj_green}, {32'h1, STR_PROJ_OFF, 1'h0});
    autooff_en <= 1'h0;
    same_code <= 1'h1;
    u_far.push(BTN_PROJ, 12);
    count_blink();
    check(ones > 0 && ones < 16, 1'h1);
    @(posedge sys_clk);
    same_code <= 1'h0;
    nv_valid <= ~nv_valid;
    reset_n <= 1'h0;
    repeat (3) @(posedge sys_clk);
    check({settings, leds}, {2'h0, {4{5'h10}}, 7'h20, 2'h0, LED_ALL_OFF});
    reset_n <= 1'h1;
    repeat (45) @(posedge sys_clk);
    check(leds.in_sel, 4'h1);
    final_report();
  end
endmodule : tb_top

bind av_panel_control av_panel_properties #(.FLASH_CYC(FLASH_CYC)) u_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .same_code(same_code), .warm_secs(warm_secs), .cool_secs(cool_secs), .settings(settings), .nv_write(nv_write),
  .leds(leds), .serial_req(serial_req), .eq_hf_level(eq_hf_level));

// *** include/av_panel_pkg.sv ***
// Package with constants and types shared by the front-panel control logic.
package av_panel_pkg;

  // System clock rate and time constants in their own units.
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned HOLD_MS     = 500;
  localparam int unsigned REPEAT_MS   = 100;
  localparam int unsigned BLINK_MS    = 250;
  localparam int unsigned BURST_MS    = 1000;
  localparam int unsigned FLASH_MS    = 500;
  localparam int unsigned SEC_MS      = 1000;

  // Cycle counts derived from the times; every one exceeds 4096 and is a top parameter default.
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned HOLD_CYC     = (CLK_HZ / 1000) * HOLD_MS;
  localparam int unsigned REPEAT_CYC   = (CLK_HZ / 1000) * REPEAT_MS;
  localparam int unsigned BLINK_CYC    = (CLK_HZ / 1000) * BLINK_MS;
  localparam int unsigned BURST_CYC    = (CLK_HZ / 1000) * BURST_MS;
  localparam int unsigned FLASH_CYC    = (CLK_HZ / 1000) * FLASH_MS;
  localparam int unsigned SEC_CYC      = (CLK_HZ / 1000) * SEC_MS;

  // Button indices within the button pin vector.
  localparam int unsigned NUM_IN    = 4;
  localparam int unsigned BTN_BLANK = 4;
  localparam int unsigned BTN_PROJ  = 5;
  localparam int unsigned BTN_VUP   = 6;
  localparam int unsigned BTN_VDN   = 7;
  localparam int unsigned BTN_MUTE  = 8;
  localparam int unsigned BTN_EQSEL = 9;
  localparam int unsigned BTN_EQP   = 10;
  localparam int unsigned BTN_EQM   = 11;
  localparam int unsigned NUM_BTN   = 12;

  // Level widths, limits and reset values.
  localparam int unsigned VOL_W     = 7;
  localparam int unsigned LEVEL_W   = 5;
  localparam int unsigned EQ_W      = 4;
  localparam logic [7:0]  VOL_MAX   = 8'h40;
  localparam logic [7:0]  LEVEL_MAX = 8'h1F;
  localparam logic [7:0]  EQ_MAX    = 8'h0F;
  localparam logic [VOL_W-1:0]   VOL_RST   = 7'h20;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 5'h10;
  localparam logic [EQ_W-1:0]    EQ_RST    = 4'h8;

  // Serial string identifiers sent toward the receiver.
  localparam logic [2:0] STR_PROJ_ON  = 3'h4;
  localparam logic [2:0] STR_PROJ_OFF = 3'h5;

  // Debounced button events.
  typedef struct packed {
    logic press;
    logic release_ev;
    logic held;
    logic rpt;
  } btn_event_t;

  // Settings kept in non-volatile storage.
  typedef struct packed {
    logic [1:0]                      sel;
    logic [NUM_IN-1:0][LEVEL_W-1:0]  level;
    logic [VOL_W-1:0]                volume;
    logic                            blank;
    logic                            mute;
  } nv_settings_t;

  // Front-panel indicators of transmitter and receiver.
  typedef struct packed {
    logic [NUM_IN-1:0] in_sel;
    logic              blank;
    logic              mute;
    logic              proj_green;
    logic              tx_power;
    logic              rx_power;
    logic              eq_hf;
    logic              eq_lf;
  } led_t;

  // One serial string request toward the receiver.
  typedef struct packed {
    logic       valid;
    logic [2:0] id;
  } serial_req_t;

  localparam led_t LED_ALL_ON  = 11'h7FF;
  localparam led_t LED_ALL_OFF = 11'h000;

endpackage : av_panel_pkg

// *** logic/av_panel_control.sv ***
// Front-panel control of the twisted-pair switcher: selection, mutes, projector power, volume and equalization.
// Function
// - Each input button selects that input for forwarded video and local audio.
// - Pressing an input with a programmed string sends that string to the receiver.
// - Blank button toggles video mute; blank indicator lit while muted, sync kept.
// - Projector indicator green after power-on command, dark after power-off command.
// - During warm-up or cool-down delay the indicator blinks and buttons are ignored.
// - With identical on and off strings the indicator blinks on every press.
// - Mute button toggles audio mute; output silent and mute indicator lit.
// - Power-up flashes all LEDs once, then shows selection, power and HF indicators.
// - Selection, levels, volume, blank and mute are saved and restored at power-up.
// - First projector command is power-on; later presses alternate off and on.
// - From off or nothing sent, press sends on, lights indicator, starts auto-off.
// - From on, press sends power-off string and extinguishes the indicator.
// - Auto-off expiry acts exactly like a press while power-on was last.
// - Volume press steps output volume once; holding ramps it continuously.
// - While an input button is held, volume buttons change that input's level.
// - Equalization select toggles band between high and low; indicator follows.
// - Equalization adjust raises selected band on plus, lowers on minus.
`timescale 1ns/1ps
module av_panel_control #(
  parameter int unsigned DEBOUNCE_CYC = av_panel_pkg::DEBOUNCE_CYC,
  parameter int unsigned HOLD_CYC     = av_panel_pkg::HOLD_CYC,
  parameter int unsigned REPEAT_CYC   = av_panel_pkg::REPEAT_CYC,
  parameter int unsigned BLINK_CYC    = av_panel_pkg::BLINK_CYC,
  parameter int unsigned BURST_CYC    = av_panel_pkg::BURST_CYC,
  parameter int unsigned FLASH_CYC    = av_panel_pkg::FLASH_CYC,
  parameter int unsigned SEC_CYC      = av_panel_pkg::SEC_CYC
) (
  input  wire logic                              sys_clk,
  input  wire logic                              reset_n,
  input  wire logic [av_panel_pkg::NUM_BTN-1:0]  buttons_n,
  input  wire logic [av_panel_pkg::NUM_IN-1:0]   str_present,
  input  wire logic                              same_code,
  input  wire logic [7:0]                        warm_secs,
  input  wire logic [7:0]                        cool_secs,
  input  wire logic                              autooff_en,
  input  wire logic [15:0]                       autooff_secs,
  input  av_panel_pkg::nv_settings_t             nv_data,
  input  wire logic                              nv_valid,
  output av_panel_pkg::nv_settings_t             settings,
  output logic                                   nv_write,
  output av_panel_pkg::led_t                     leds,
  output av_panel_pkg::serial_req_t              serial_req,
  output logic [av_panel_pkg::EQ_W-1:0]          eq_hf_level,
  output logic [av_panel_pkg::EQ_W-1:0]          eq_lf_level
);
  import av_panel_pkg::*;

  typedef enum logic [3:0] {
    ST_TEST_ON  = 4'b0001,
    ST_TEST_OFF = 4'b0010,
    ST_RUN      = 4'b0100,
    ST_DELAY    = 4'b1000
  } panel_state_t;

  btn_event_t   ev [NUM_BTN];
  panel_state_t state;
  nv_settings_t next_settings;
  logic         load_done;
  logic         run;
  logic         proj_on;
  logic         send_on;
  logic         send_off;
  logic         expire;
  logic [7:0]   delay_pick;
  logic [7:0]   delay_left;
  logic [15:0]  autooff_left;
  logic [31:0]  flash_cnt;
  logic [31:0]  sec_cnt;
  logic         sec_tick;
  logic [31:0]  blink_cnt;
  logic         blink_phase;
  logic [31:0]  burst_left;
  logic         eq_hf;
  logic         up_step;
  logic         dn_step;

  // Saturating one-step change used for volume, input levels and equalization.
  function automatic logic [7:0] step_level(input logic [7:0] v, input logic up, input logic dn,
                                            input logic [7:0] maxv);
    logic [7:0] r;
    r = v;
    if (up && !dn && v < maxv)
      r = v + 8'h01;
    else if (dn && !up && v != 8'h00)
      r = v - 8'h01;
    return r;
  endfunction : step_level

  // One debouncer per front-panel button.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BTN; gi++)
    begin : g_btn
      button_debounce #(
        .DEBOUNCE_CYC (DEBOUNCE_CYC),
        .HOLD_CYC     (HOLD_CYC),
        .REPEAT_CYC   (REPEAT_CYC)
      ) u_db (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .button_n (buttons_n[gi]),
        .ev       (ev[gi])
      );
    end
  endgenerate

  // Buttons act only in normal operation, never during self-test or a projector delay.
  assign run     = (state == ST_RUN);
  assign up_step = ev[BTN_VUP].press | ev[BTN_VUP].rpt;
  assign dn_step = ev[BTN_VDN].press | ev[BTN_VDN].rpt;

  // Projector command decision: press or auto-off expiry, alternating on and off.
  always_comb
  begin
    expire     = run && proj_on && autooff_left == 16'h0001 && sec_tick;
    send_on    = run && ev[BTN_PROJ].press && !proj_on;
    send_off   = run && proj_on && (ev[BTN_PROJ].press || expire);
    delay_pick = send_on ? warm_secs : cool_secs;
  end

  // Power-up self-test flash and projector delay sequencing.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state      <= ST_TEST_ON;
      flash_cnt  <= 32'h0;
      delay_left <= 8'h00;
    end
    else
    begin
      case (state)
        ST_TEST_ON:
        begin
          if (flash_cnt >= FLASH_CYC - 1)
          begin
            flash_cnt <= 32'h0;
            state     <= ST_TEST_OFF;
          end
          else
            flash_cnt <= flash_cnt + 32'h1;
        end
        ST_TEST_OFF:
        begin
          if (flash_cnt >= FLASH_CYC - 1)
          begin
            flash_cnt <= 32'h0;
            state     <= ST_RUN;
          end
          else
            flash_cnt <= flash_cnt + 32'h1;
        end
        ST_RUN:
        begin
          if ((send_on || send_off) && delay_pick != 8'h00)
          begin
            delay_left <= delay_pick;
            state      <= ST_DELAY;
          end
        end
        ST_DELAY:
        begin
          if (sec_tick)
          begin
            delay_left <= delay_left - 8'h01;
            if (delay_left == 8'h01)
              state <= ST_RUN;
          end
        end
        default:
          state <= ST_TEST_ON;
      endcase
    end
  end

  // Next stored settings: restore once after reset, then follow the buttons.
  always_comb
  begin
    next_settings = settings;
    if (!load_done)
    begin
      if (nv_valid)
        next_settings = nv_data;
    end
    else if (run)
    begin
      for (int i = 0; i < NUM_IN; i++)
      begin
        if (ev[i].press)
          next_settings.sel = 2'(i);
      end
      if (ev[BTN_BLANK].press)
        next_settings.blank = ~settings.blank;
      if (ev[BTN_MUTE].press)
        next_settings.mute = ~settings.mute;
      if (ev[0].held || ev[1].held || ev[2].held || ev[3].held)
      begin
        for (int i = NUM_IN - 1; i >= 0; i--)
        begin
          if (ev[i].held)
            next_settings.level[i] = LEVEL_W'(step_level(8'(settings.level[i]), up_step, dn_step,
                                                         LEVEL_MAX));
        end
      end
      else
        next_settings.volume = VOL_W'(step_level(8'(settings.volume), up_step, dn_step, VOL_MAX));
    end
  end

  // Stored settings and the save strobe on every change after the restore.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      settings  <= '{sel: 2'h0, level: {NUM_IN{LEVEL_RST}}, volume: VOL_RST, blank: 1'b0, mute: 1'b0};
      load_done <= 1'b0;
      nv_write  <= 1'b0;
    end
    else
    begin
      settings  <= next_settings;
      load_done <= 1'b1;
      nv_write  <= load_done && (next_settings != settings);
    end
  end

  // Projector power state and auto-off countdown in whole seconds.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      proj_on      <= 1'b0;
      autooff_left <= 16'h0000;
    end
    else if (send_on)
    begin
      proj_on      <= 1'b1;
      autooff_left <= autooff_en ? autooff_secs : 16'h0000;
    end
    else if (send_off)
    begin
      proj_on      <= 1'b0;
      autooff_left <= 16'h0000;
    end
    else if (run && sec_tick && autooff_left != 16'h0000)
      autooff_left <= autooff_left - 16'h0001;
  end

  // Serial string requests toward the receiver; projector strings take priority.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      serial_req <= '0;
    else
    begin
      serial_req.valid <= 1'b0;
      if (send_on)
        serial_req <= '{valid: 1'b1, id: STR_PROJ_ON};
      else if (send_off)
        serial_req <= '{valid: 1'b1, id: STR_PROJ_OFF};
      else if (run)
      begin
        for (int i = 0; i < NUM_IN; i++)
        begin
          if (ev[i].press && str_present[i])
            serial_req <= '{valid: 1'b1, id: 3'(i)};
        end
      end
    end
  end

  // Second tick, restarted on each projector command so delays run full seconds.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sec_cnt  <= 32'h0;
      sec_tick <= 1'b0;
    end
    else if (send_on || send_off)
    begin
      sec_cnt  <= 32'h0;
      sec_tick <= 1'b0;
    end
    else
    begin
      sec_tick <= (sec_cnt >= SEC_CYC - 1);
      sec_cnt  <= (sec_cnt >= SEC_CYC - 1) ? 32'h0 : sec_cnt + 32'h1;
    end
  end

  // Blink rate divider and the blink burst shown when on and off strings are identical.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      blink_cnt   <= 32'h0;
      blink_phase <= 1'b0;
      burst_left  <= 32'h0;
    end
    else
    begin
      if (blink_cnt >= BLINK_CYC - 1)
      begin
        blink_cnt   <= 32'h0;
        blink_phase <= ~blink_phase;
      end
      else
        blink_cnt <= blink_cnt + 32'h1;
      if ((send_on || send_off) && same_code)
        burst_left <= BURST_CYC;
      else if (burst_left != 32'h0)
        burst_left <= burst_left - 32'h1;
    end
  end

  // Receiver equalization band select and per-band adjust.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      eq_hf       <= 1'b1;
      eq_hf_level <= EQ_RST;
      eq_lf_level <= EQ_RST;
    end
    else if (run)
    begin
      if (ev[BTN_EQSEL].press)
        eq_hf <= ~eq_hf;
      if (eq_hf)
        eq_hf_level <= EQ_W'(step_level(8'(eq_hf_level), ev[BTN_EQP].press | ev[BTN_EQP].rpt,
                                        ev[BTN_EQM].press | ev[BTN_EQM].rpt, EQ_MAX));
      else
        eq_lf_level <= EQ_W'(step_level(8'(eq_lf_level), ev[BTN_EQP].press | ev[BTN_EQP].rpt,
                                        ev[BTN_EQM].press | ev[BTN_EQM].rpt, EQ_MAX));
    end
  end

  // Indicator drive: self-test pattern first, then live state.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      leds <= LED_ALL_OFF;
    else if (state == ST_TEST_ON)
      leds <= LED_ALL_ON;
    else if (state == ST_TEST_OFF)
      leds <= LED_ALL_OFF;
    else
    begin
      leds.in_sel     <= NUM_IN'(4'h1 << settings.sel);
      leds.blank      <= settings.blank;
      leds.mute       <= settings.mute;
      leds.tx_power   <= 1'b1;
      leds.rx_power   <= 1'b1;
      leds.eq_hf      <= eq_hf;
      leds.eq_lf      <= ~eq_hf;
      if (state == ST_DELAY || burst_left != 32'h0)
        leds.proj_green <= blink_phase;
      else
        leds.proj_green <= proj_on;
    end
  end

endmodule : av_panel_control

// *** logic/button_debounce.sv ***
// Button synchroniser, debouncer and press, release and hold detector.
`timescale 1ns/1ps
module button_debounce #(
  parameter int unsigned DEBOUNCE_CYC = av_panel_pkg::DEBOUNCE_CYC,
  parameter int unsigned HOLD_CYC     = av_panel_pkg::HOLD_CYC,
  parameter int unsigned REPEAT_CYC   = av_panel_pkg::REPEAT_CYC
) (
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  input  wire logic                     button_n,
  output av_panel_pkg::btn_event_t      ev
);
  import av_panel_pkg::*;

  logic [2:0]  sync;
  logic        level;
  logic [31:0] cnt;
  logic [31:0] hcnt;

  // Three-stage synchroniser; only the agreeing second and third stages are used.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      sync <= 3'h0;
    else
      sync <= {sync[1:0], ~button_n};
  end

  // Stable level is taken only after the input agrees for the full debounce time.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      level <= 1'b0;
      cnt   <= 32'h0;
    end
    else if (sync[1] == sync[2] && sync[2] != level)
    begin
      if (cnt >= DEBOUNCE_CYC - 1)
      begin
        level <= sync[2];
        cnt   <= 32'h0;
      end
      else
        cnt <= cnt + 32'h1;
    end
    else
      cnt <= 32'h0;
  end

  // Edge pulses, held level and auto-repeat pulses while held.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ev   <= '0;
      hcnt <= 32'h0;
    end
    else
    begin
      ev.press      <= level & ~ev.held;
      ev.release_ev <= ~level & ev.held;
      ev.held       <= level;
      ev.rpt        <= 1'b0;
      if (!level)
        hcnt <= 32'h0;
      else if (hcnt >= HOLD_CYC - 1)
      begin
        ev.rpt <= 1'b1;
        hcnt   <= HOLD_CYC - REPEAT_CYC;
      end
      else
        hcnt <= hcnt + 32'h1;
    end
  end

endmodule : button_debounce
